/* sst_params.svh */
// offsets, field positions, reset values and timing counts of the serial transmitter
`ifndef SST_PARAMS_SVH
`define SST_PARAMS_SVH

`define SST_OFF_CTRL 8'h00
`define SST_OFF_TXBUF 8'h04
`define SST_OFF_STATUS 8'h08
`define SST_OFF_IRQ_STAT 8'h0c
`define SST_OFF_IRQ_CLR 8'h10
`define SST_OFF_IRQ_EN 8'h14

`define SST_CTRL_MODE_LSB 0
`define SST_CTRL_CLKSEL_BIT 2
`define SST_CTRL_DIR_BIT 3
`define SST_CTRL_START_BIT 7

`define SST_ST_TXEMPTY_BIT 0
`define SST_ST_ACTIVE_BIT 1
`define SST_ST_SHIFT_BIT 2

`define SST_IRQ_DONE_BIT 0

`define SST_MODE_TX 2'h0
`define SST_CTRL_RESET 8'h00
`define SST_TXBUF_RESET 8'h00
`define SST_BITS_PER_BYTE 4'h8

`define SST_CLK_PERIOD_NS 8
`define SST_SCK_HALF_NS 64
`define SST_SCK_HALF_CYC (((`SST_SCK_HALF_NS) + (`SST_CLK_PERIOD_NS) - 1) / (`SST_CLK_PERIOD_NS))

`define SST_RESP_OKAY 2'h0
`define SST_RESP_SLVERR 2'h2

`endif

/* sst_pkg.sv */
// types shared by the serial transmitter
`default_nettype none
package sst_pkg;
	typedef struct packed {
		logic start;
		logic [2:0] unused;
		logic dir_lsb;
		logic clk_ext;
		logic [1:0] mode;
	} sst_ctrl_t;

	typedef struct packed {
		logic shift_active;
		logic transfer_active;
		logic tx_empty;
	} sst_status_t;

	typedef enum logic [1:0] {
		SST_IDLE = 2'b00,
		SST_SHIFT = 2'b01,
		SST_LAST = 2'b11
	} sst_state_t;
endpackage
`default_nettype wire

/* sst_top.sv */
// synchronous serial transmitter with axi4-lite register slave
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "sst_params.svh"

// Function
// - mode code 00 selects transmit operation
// - clock select bit picks internal or external
// - buffer write clears buffer empty flag
// - transfer flag set on serial falling edge
// - bits shift out on falling edges, ordered
// - shift flag high first fall to eighth rise
// - empty set on rise, interrupt next fall
// - internal clock waits for buffered byte
// - internal load within one period, clock out
// - external load on first incoming fall
// - direction 0 msb first, 1 lsb first
module sst_top
	import sst_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	output logic so_out,
	output logic irq
);
	localparam logic [7:0] SCK_HALF = 8'(`SST_SCK_HALF_CYC);

	sst_ctrl_t ctrl_r;
	sst_status_t stat_r;
	sst_state_t state_r;
	logic [7:0] txbuf_r, shreg_r, div_r, awaddr_q_r;
	logic [31:0] wdata_q_r;
	logic [3:0] cnt_r, wstrb_q_r;
	logic [0:0] irq_stat_r, irq_en_r;
	logic buf_full_r, pend_empty_r, pend_irq_r, running_r, sck_gen_r;
	logic sck_s1_r, sck_s2_r, sck_s3_r, aw_hold_r, w_hold_r;
	logic go, fall_ev, rise_ev, wr_do, wr_lane0, wr_txbuf, wr_clr, load_ev, done_set, rd_ok;
	logic [7:0] first_bits, rd_data;

	assign go = ctrl_r.start && (ctrl_r.mode == `SST_MODE_TX);

	// serial clock edges from the generator or the synchronised pin
	always_comb begin
		if (ctrl_r.clk_ext) begin
			fall_ev = sck_s3_r && !sck_s2_r;
			rise_ev = !sck_s3_r && sck_s2_r;
		end else begin
			fall_ev = running_r && (div_r == SCK_HALF - 8'h01) && sck_gen_r;
			rise_ev = running_r && (div_r == SCK_HALF - 8'h01) && !sck_gen_r;
		end
	end

	// byte moves into the shifter at a falling edge between bytes
	assign load_ev = go && fall_ev && (state_r != SST_SHIFT) && buf_full_r;
	assign first_bits = ctrl_r.dir_lsb ? txbuf_r : {txbuf_r[0], txbuf_r[1], txbuf_r[2], txbuf_r[3],
		txbuf_r[4], txbuf_r[5], txbuf_r[6], txbuf_r[7]};

	// external pin synchroniser plus edge history
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sck_s1_r <= 1'b1;
			sck_s2_r <= 1'b1;
			sck_s3_r <= 1'b1;
		end else begin
			sck_s1_r <= sck_in;
			sck_s2_r <= sck_s1_r;
			sck_s3_r <= sck_s2_r;
		end
	end

	// internal clock generator; idles high
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			running_r <= 1'b0;
			div_r <= 8'h00;
			sck_gen_r <= 1'b1;
		end else if (!go || ctrl_r.clk_ext) begin
			running_r <= 1'b0;
			div_r <= 8'h00;
			sck_gen_r <= 1'b1;
		end else if (!running_r) begin
			div_r <= 8'h00;
			sck_gen_r <= 1'b1;
			if (buf_full_r) begin
				running_r <= 1'b1;
			end
		end else begin
			if (div_r == SCK_HALF - 8'h01) begin
				div_r <= 8'h00;
				sck_gen_r <= !sck_gen_r;
				if (rise_ev && state_r == SST_LAST && !buf_full_r) begin
					running_r <= 1'b0;
				end
			end else begin
				div_r <= div_r + 8'h01;
			end
		end
	end

	// clock pin drive
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sck_out <= 1'b1;
			sck_oe <= 1'b0;
		end else begin
			sck_out <= sck_gen_r;
			sck_oe <= (ctrl_r.mode == `SST_MODE_TX) && !ctrl_r.clk_ext;
		end
	end

	// shift engine
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= SST_IDLE;
			shreg_r <= 8'h00;
			cnt_r <= 4'h0;
			so_out <= 1'b1;
		end else if (!go) begin
			state_r <= SST_IDLE;
			cnt_r <= 4'h0;
		end else if (load_ev) begin
			shreg_r <= {1'b0, first_bits[7:1]};
			so_out <= first_bits[0];
			cnt_r <= 4'h1;
			state_r <= SST_SHIFT;
		end else if (fall_ev && state_r == SST_SHIFT) begin
			so_out <= shreg_r[0];
			shreg_r <= {1'b0, shreg_r[7:1]};
			cnt_r <= cnt_r + 4'h1;
			if (cnt_r == `SST_BITS_PER_BYTE - 4'h1) begin
				state_r <= SST_LAST;
			end
		end else if (rise_ev && state_r == SST_LAST) begin
			state_r <= SST_IDLE;
			cnt_r <= 4'h0;
		end
	end

	// status flags
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat_r.tx_empty <= 1'b1;
			stat_r.transfer_active <= 1'b0;
			stat_r.shift_active <= 1'b0;
			pend_empty_r <= 1'b0;
			pend_irq_r <= 1'b0;
		end else begin
			if (wr_txbuf) begin
				stat_r.tx_empty <= 1'b0;
			end else if (rise_ev && pend_empty_r) begin
				stat_r.tx_empty <= !buf_full_r;
			end
			if (load_ev) begin
				pend_empty_r <= 1'b1;
			end else if (rise_ev) begin
				pend_empty_r <= 1'b0;
			end
			if (rise_ev && pend_empty_r) begin
				pend_irq_r <= 1'b1;
			end else if (fall_ev || !go) begin
				pend_irq_r <= 1'b0;
			end
			if (load_ev) begin
				stat_r.transfer_active <= 1'b1;
				stat_r.shift_active <= 1'b1;
			end else if (!go) begin
				stat_r.transfer_active <= 1'b0;
				stat_r.shift_active <= 1'b0;
			end else if (rise_ev && state_r == SST_LAST) begin
				stat_r.shift_active <= 1'b0;
				if (!buf_full_r) begin
					stat_r.transfer_active <= 1'b0;
				end
			end
		end
	end
	assign done_set = fall_ev && pend_irq_r && go;
	// transmit buffer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			txbuf_r <= `SST_TXBUF_RESET;
			buf_full_r <= 1'b0;
		end else if (wr_txbuf) begin
			txbuf_r <= wdata_q_r[7:0];
			buf_full_r <= 1'b1;
		end else if (load_ev) begin
			buf_full_r <= 1'b0;
		end
	end

	// write channel capture
	assign wr_do = aw_hold_r && w_hold_r && !s_axi_bvalid;
	assign wr_lane0 = wr_do && wstrb_q_r[0];
	assign wr_txbuf = wr_lane0 && (awaddr_q_r == `SST_OFF_TXBUF);
	assign wr_clr = wr_lane0 && (awaddr_q_r == `SST_OFF_IRQ_CLR);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_q_r <= 8'h00;
			wdata_q_r <= 32'h00000000;
			wstrb_q_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SST_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_hold_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready <= !w_hold_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				awaddr_q_r <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				wdata_q_r <= s_axi_wdata;
				wstrb_q_r <= s_axi_wstrb;
			end
			if (wr_do) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				s_axi_awready <= 1'b0;
				s_axi_wready <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (awaddr_q_r)
					`SST_OFF_CTRL, `SST_OFF_TXBUF, `SST_OFF_IRQ_CLR, `SST_OFF_IRQ_EN: begin
						s_axi_bresp <= `SST_RESP_OKAY;
					end
					default: begin
						s_axi_bresp <= `SST_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// control and interrupt enable registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= `SST_CTRL_RESET;
			irq_en_r <= 1'b0;
		end else if (wr_lane0) begin
			if (awaddr_q_r == `SST_OFF_CTRL) begin
				ctrl_r.mode <= wdata_q_r[`SST_CTRL_MODE_LSB +: 2];
				ctrl_r.clk_ext <= wdata_q_r[`SST_CTRL_CLKSEL_BIT];
				ctrl_r.dir_lsb <= wdata_q_r[`SST_CTRL_DIR_BIT];
				ctrl_r.unused <= 3'h0;
				ctrl_r.start <= wdata_q_r[`SST_CTRL_START_BIT];
			end
			if (awaddr_q_r == `SST_OFF_IRQ_EN) begin
				irq_en_r <= wdata_q_r[`SST_IRQ_DONE_BIT];
			end
		end
	end

	// sticky interrupt status; a set beats a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_r <= 1'b0;
			irq <= 1'b0;
		end else begin
			if (done_set) begin
				irq_stat_r <= 1'b1;
			end else if (wr_clr && wdata_q_r[`SST_IRQ_DONE_BIT]) begin
				irq_stat_r <= 1'b0;
			end
			irq <= |(irq_stat_r & irq_en_r);
		end
	end

	// read decode
	always_comb begin
		rd_data = 8'h00;
		rd_ok = 1'b1;
		case ({s_axi_araddr[7:2], 2'b00})
			`SST_OFF_CTRL: begin
				rd_data = {ctrl_r.start, 3'h0, ctrl_r.dir_lsb, ctrl_r.clk_ext, ctrl_r.mode};
			end
			`SST_OFF_STATUS: begin
				rd_data = {5'h00, stat_r.shift_active, stat_r.transfer_active, stat_r.tx_empty};
			end
			`SST_OFF_IRQ_STAT: begin
				rd_data = {7'h00, irq_stat_r};
			end
			`SST_OFF_IRQ_EN: begin
				rd_data = {7'h00, irq_en_r};
			end
			`SST_OFF_TXBUF, `SST_OFF_IRQ_CLR: begin
				rd_data = 8'h00;
			end
			default: begin
				rd_ok = 1'b0;
			end
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `SST_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_data};
			s_axi_rresp <= rd_ok ? `SST_RESP_OKAY : `SST_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end
endmodule
`default_nettype wire

/* sst_chk.sv */
// port assertions for the serial transmitter
`timescale 1ns/1ns
`default_nettype none
module sst_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sck_out,
	input wire logic sck_oe
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence low_half;
		!sck_out [*8] ##1 sck_out;
	endsequence
	sequence high_half;
		sck_out [*8];
	endsequence
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_write_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1 s_axi_awready && s_axi_wready)
		else $error("write channel not released");
	chk_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready)
		else $error("read channel not released");
	chk_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	chk_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	chk_sck_low_half: assert property (sck_oe && $fell(sck_out) |-> low_half)
		else $error("serial clock low phase wrong");
	chk_sck_high_half: assert property (sck_oe && $rose(sck_out) |-> high_half)
		else $error("serial clock high phase short");
endmodule
bind sst_top sst_chk i_chk (.*);
`default_nettype wire

/* sst_peer.sv */
// far side: serial clock source and bit sampler
`timescale 1ns/1ns
`default_nettype none
module sst_peer (
	input wire logic go,
	input wire logic sck_line,
	input wire logic so_out,
	output logic sck_drv,
	output logic [7:0] got
);
	initial begin
		sck_drv = 1'b1;
		got = 8'h00;
	end
	always @(posedge go) begin
		repeat (8) begin
			#62 sck_drv = 1'b0;
			#63 sck_drv = 1'b1;
		end
	end
	always @(posedge sck_line) got <= {got[6:0], so_out};
endmodule
`default_nettype wire

/* testbench.sv */
// bench for the serial transmitter
`timescale 1ns/1ns
`default_nettype none
module testbench;
	typedef struct packed {logic [7:0] ctrl; logic [7:0] data; logic [7:0] line;} sst_row_t;
	sst_row_t rows [4] = '{'{8'h80, 8'hc1, 8'hc1}, '{8'h88, 8'hc1, 8'h83}, '{8'h84, 8'h2d, 8'h2d}, '{8'h8c, 8'h2d, 8'hb4}};
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sck_out, sck_oe, so_out, irq, sck_drv, go;
	logic [7:0] s_axi_awaddr, s_axi_araddr, got;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	int num_errors, total_checks, n;
	wire logic sck_in = sck_oe ? sck_out : sck_drv;
	sst_top i_dut (.*);
	sst_peer i_peer (.go(go), .sck_line(sck_in), .so_out(so_out), .sck_drv(sck_drv), .got(got));
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	task automatic check(input string m, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", m, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		r = s_axi_bresp;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		v = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	task automatic st(input string m, input logic [2:0] e);
		rd(8'h08);
		check(m, e, v[2:0]);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#500000;
		num_errors++;
		give_verdict;
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, go} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		wr(8'h14, 1);
		foreach (rows[i]) begin
			wr(8'h00, rows[i].ctrl);
			wr(8'h04, rows[i].data);
			st("empty flag", 3'b000);
			go <= rows[i].ctrl[2];
			for (n = 0; n < 900 && irq !== 1'b1; n++) @(posedge aclk);
			check("irq in time", 1, irq);
			go <= 1'b0;
			st("busy flags", 3'b111);
			rd(8'h0c);
			check("done event", 1, v);
			v = 32'h2;
			for (n = 0; n < 99 && v[1] !== 1'b0; n++) rd(8'h08);
			check("active cleared", 0, v[1]);
			check("line byte", rows[i].line, got);
			st("idle flags", 3'b001);
			wr(8'h10, 1);
			check("clear resp", 0, r);
			@(posedge aclk);
			#1 check("irq cleared", 0, irq);
			$display("row %0d done", i);
		end
		wr(8'h00, 8'h80);
		repeat (40) @(posedge aclk);
		st("start without data", 3'b001);
		check("idle clock", 1, sck_out);
		wr(8'h00, 8'h81);
		wr(8'h04, 8'h55);
		repeat (40) @(posedge aclk);
		st("other mode", 3'b000);
		check("clock drive off", 0, sck_oe);
		wr(8'h00, 8'h80);
		repeat (30) @(posedge aclk);
		st("late start", 3'b111);
		check("clock drive on", 1, sck_oe);
		repeat (200) @(posedge aclk);
		check("irq raised", 1, irq);
		wr(8'h14, 0);
		@(posedge aclk);
		#1 check("masked irq", 0, irq);
		rd(8'h0c);
		check("event kept", 1, v);
		rd(8'h18);
		check("unmapped resp", 2'h2, r);
		wr(8'h18, 0);
		check("unmapped write resp", 2'h2, r);
		$display("edge cases done");
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		st("reset flags", 3'b001);
		rd(8'h0c);
		check("reset event", 0, v);
		$display("reset test done");
		give_verdict;
	end
endmodule
`default_nettype wire
